// ---- src/tpr_map.svh ----
`ifndef TPR_MAP_SVH
`define TPR_MAP_SVH
`define TPR_MIN_DEPTH 4
`define TPR_MAX_DEPTH 2048
`define TPR_MIN_WIDTH 2
`define TPR_MAX_WIDTH 72
`define TPR_MIN_BITS 64
`define TPR_MAX_BITS 18432
// ns per phase; each phase holds pins for whole clocks
`define TPR_CLK_NS 10
`define TPR_SETUP_NS 10
`define TPR_PULSE_NS 30
`define TPR_ACCESS_NS 30
`define TPR_SETUP_CYC ((`TPR_SETUP_NS + `TPR_CLK_NS - 1) / `TPR_CLK_NS)
`define TPR_PULSE_CYC ((`TPR_PULSE_NS + `TPR_CLK_NS - 1) / `TPR_CLK_NS)
`define TPR_ACCESS_CYC ((`TPR_ACCESS_NS + `TPR_CLK_NS - 1) / `TPR_CLK_NS)
`endif

// ---- src/tpr_pkg.sv ----
package tpr_pkg;
	typedef enum logic [4:0] {
		TPR_IDLE  = 5'h01,
		TPR_SETUP = 5'h02,
		TPR_PULSE = 5'h04,
		TPR_HOLD  = 5'h08,
		TPR_DONE  = 5'h10
	} tpr_state_t;
	typedef enum logic [1:0] {
		TPR_OP_READ   = 2'h0,
		TPR_OP_WR_WE  = 2'h1,
		TPR_OP_WR_EN  = 2'h2
	} tpr_op_t;
endpackage : tpr_pkg

// ---- src/tpr_pins_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tpr_pins_if #(
	parameter int AW = 11
);
	logic [AW-1:0] addr;
	logic          strobe_n;
	logic          load;
	logic [AW-1:0] next_addr;
	logic          next_strobe_n;
	modport drv (input load, next_addr, next_strobe_n, output addr, strobe_n);
	modport ctl (output load, next_addr, next_strobe_n, input addr, strobe_n);
endinterface : tpr_pins_if
`default_nettype wire

// ---- src/tpr_read_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// holds one read-only port's address and enable pins
module tpr_read_port
	import tpr_pkg::*;
#(
	parameter int AW = 11
) (
	input  wire logic REF_CLK,
	input  wire logic RST,
	tpr_pins_if.drv   pins
);
	typedef struct packed {
		logic [AW-1:0] addr;
		logic          strobe_n;
	} tpr_rp_t;
	tpr_rp_t st;
	tpr_rp_t next_st;
	always_comb begin
		next_st = st;
		if (pins.load) begin
			next_st.addr     = pins.next_addr;
			next_st.strobe_n = pins.next_strobe_n;
		end
	end
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			st <= '{addr: '0, strobe_n: 1'h1};
		end else begin
			st <= next_st;
		end
	end
	assign pins.addr     = st.addr;
	assign pins.strobe_n = st.strobe_n;
endmodule : tpr_read_port
`default_nettype wire

// ---- src/tpr_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tpr_map.svh"
// controller that drives a triple-port static RAM through its pins
module tpr_ctrl
	import tpr_pkg::*;
#(
	parameter int DEPTH = 2048,
	parameter int WIDTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             REF_CLK,
	input  wire logic             RST,
	// ****************************************
	// command side, read/write port
	// ****************************************
	input  wire logic             REQ_VALID,
	input  wire logic [1:0]       REQ_OP,
	input  wire logic [AW-1:0]    REQ_ADDR,
	input  wire logic [WIDTH-1:0] REQ_WDATA,
	output logic                  REQ_READY,
	output logic                  RSP_VALID,
	output logic [WIDTH-1:0]      RSP_RDATA,
	// ****************************************
	// read-only ports b and c, address-controlled
	// ****************************************
	input  wire logic             B_LOAD,
	input  wire logic [AW-1:0]    B_ADDR_IN,
	input  wire logic             B_EN_IN,
	input  wire logic             C_LOAD,
	input  wire logic [AW-1:0]    C_ADDR_IN,
	input  wire logic             C_EN_IN,
	// ****************************************
	// pins toward the memory
	// ****************************************
	output logic [AW-1:0]         WRITE_PORT_ADDR,
	output logic [WIDTH-1:0]      WRITE_DATA,
	output logic                  PORT_A_STROBE_N,
	output logic                  WRITE_STROBE_ALT_N,
	input  wire logic [WIDTH-1:0] PORT_A_DOUT,
	output logic [AW-1:0]         READ_PORT_B_ADDR,
	output logic                  PORT_B_STROBE_N,
	output logic [AW-1:0]         READ_PORT_C_ADDR,
	output logic                  PORT_C_STROBE_N
);
	localparam int CW = 4;
	localparam logic [CW-1:0] SETUP_CYC  = CW'(`TPR_SETUP_CYC);
	localparam logic [CW-1:0] PULSE_CYC  = CW'(`TPR_PULSE_CYC);
	localparam logic [CW-1:0] ACCESS_CYC = CW'(`TPR_ACCESS_CYC);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (DEPTH < `TPR_MIN_DEPTH || DEPTH > `TPR_MAX_DEPTH) begin : g_bad_depth
		$error("depth out of range");
	end
	if (WIDTH < `TPR_MIN_WIDTH || WIDTH > `TPR_MAX_WIDTH) begin : g_bad_width
		$error("width out of range");
	end
	if (DEPTH * WIDTH < `TPR_MIN_BITS || DEPTH * WIDTH > `TPR_MAX_BITS) begin : g_bad_bits
		$error("total size out of range");
	end
	if (AW < $clog2(DEPTH) || AW < 1) begin : g_bad_aw
		$error("address width too small");
	end
	// phase counts must fit the down-counter or a phase would wrap short
	if (`TPR_SETUP_CYC >= (1 << CW) || `TPR_PULSE_CYC >= (1 << CW) ||
		`TPR_ACCESS_CYC >= (1 << CW)) begin : g_bad_cnt
		$error("phase count too wide");
	end

	// ****************************************
	// sequencer state
	// ****************************************
	typedef struct packed {
		tpr_state_t       state;
		tpr_op_t          op;
		logic [CW-1:0]    cnt;
		logic [AW-1:0]    addr;
		logic [WIDTH-1:0] wdata;
		logic             en_n;
		logic             we_n;
		logic             ready;
		logic             rsp_valid;
		logic [WIDTH-1:0] rdata;
	} tpr_ctrl_st_t;

	tpr_ctrl_st_t st;
	tpr_ctrl_st_t next_st;

	// ****************************************
	// decoding shared by several phases
	// ****************************************
	function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
		dec = (v == '0) ? '0 : v - CW'(1);
	endfunction : dec

	// a phase ends on the edge where its count is down to one
	function automatic logic phase_end(input logic [CW-1:0] v);
		phase_end = (v <= CW'(1));
	endfunction : phase_end

	function automatic logic is_read(input tpr_op_t op);
		is_read = (op == TPR_OP_READ);
	endfunction : is_read

	// ****************************************
	// read/write port sequencer
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.rsp_valid = 1'h0;
		next_st.cnt = dec(st.cnt);
		unique case (st.state)
			TPR_IDLE: begin
				// ready falls with the take, so a second request waits out the transfer
				if (REQ_VALID && st.ready) begin
					next_st.op    = tpr_op_t'(REQ_OP);
					// address moves only while both strobes are high
					next_st.addr  = REQ_ADDR;
					next_st.wdata = REQ_WDATA;
					next_st.ready = 1'h0;
					next_st.cnt   = SETUP_CYC;
					next_st.state = TPR_SETUP;
				end
			end
			TPR_SETUP: begin
				if (phase_end(st.cnt)) begin
					next_st.en_n = 1'h0;
					// write strobe stays high on reads
					next_st.we_n = is_read(st.op);
					next_st.cnt  = is_read(st.op) ? ACCESS_CYC : PULSE_CYC;
					next_st.state = TPR_PULSE;
				end
			end
			TPR_PULSE: begin
				if (phase_end(st.cnt)) begin
					if (is_read(st.op)) begin
						// taken while the enable is still low, before the output may drift
						next_st.rdata     = PORT_A_DOUT;
						next_st.rsp_valid = 1'h1;
						next_st.en_n      = 1'h1;
					end else if (st.op == TPR_OP_WR_WE) begin
						// the strobe ends this write; the enable follows after the hold
						next_st.we_n = 1'h1;
					end else begin
						// the enable ends this write; op code 3 lands here as well
						next_st.en_n = 1'h1;
					end
					next_st.cnt   = SETUP_CYC;
					next_st.state = TPR_HOLD;
				end
			end
			TPR_HOLD: begin
				// write data held past end of write; a read's output was already sampled
				if (phase_end(st.cnt)) begin
					next_st.en_n  = 1'h1;
					next_st.we_n  = 1'h1;
					next_st.state = TPR_DONE;
				end
			end
			TPR_DONE: begin
				// one quiet cycle so both strobes are seen high before a new address
				next_st.ready = 1'h1;
				next_st.state = TPR_IDLE;
			end
			default: begin
				next_st.state = TPR_IDLE;
				next_st.en_n  = 1'h1;
				next_st.we_n  = 1'h1;
				next_st.ready = 1'h1;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			st <= '{state: TPR_IDLE, op: TPR_OP_READ, cnt: '0, addr: '0, wdata: '0,
				en_n: 1'h1, we_n: 1'h1, ready: 1'h1, rsp_valid: 1'h0, rdata: '0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// registered outputs of the read/write port
	// ****************************************
	assign REQ_READY          = st.ready;
	assign RSP_VALID          = st.rsp_valid;
	assign RSP_RDATA          = st.rdata;
	assign WRITE_PORT_ADDR    = st.addr;
	assign WRITE_DATA         = st.wdata;
	assign PORT_A_STROBE_N    = st.en_n;
	assign WRITE_STROBE_ALT_N = st.we_n;

	// ****************************************
	// read-only ports
	// ****************************************
	localparam int NRP = 2;
	logic [NRP-1:0]              rp_load;
	logic [NRP-1:0][AW-1:0]      rp_addr_in;
	logic [NRP-1:0]              rp_en_in;
	wire logic [NRP-1:0][AW-1:0] rp_addr;
	wire logic [NRP-1:0]         rp_strobe_n;

	// element 0 is port b, element 1 is port c
	assign rp_load    = {C_LOAD, B_LOAD};
	assign rp_addr_in = {C_ADDR_IN, B_ADDR_IN};
	assign rp_en_in   = {C_EN_IN, B_EN_IN};

	for (genvar g = 0; g < NRP; g++) begin : g_read_port
		tpr_pins_if #(.AW(AW)) rp_pins ();
		assign rp_pins.load          = rp_load[g];
		assign rp_pins.next_addr     = rp_addr_in[g];
		// enable held at the loaded level: reads follow the address
		assign rp_pins.next_strobe_n = ~rp_en_in[g];
		tpr_read_port #(.AW(AW)) u_port (
			.REF_CLK (REF_CLK),
			.RST     (RST),
			.pins    (rp_pins.drv)
		);
		assign rp_addr[g]     = rp_pins.addr;
		assign rp_strobe_n[g] = rp_pins.strobe_n;
	end

	assign READ_PORT_B_ADDR = rp_addr[0];
	assign PORT_B_STROBE_N  = rp_strobe_n[0];
	assign READ_PORT_C_ADDR = rp_addr[1];
	assign PORT_C_STROBE_N  = rp_strobe_n[1];
endmodule : tpr_ctrl
`default_nettype wire

// ---- verif/tpr_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpr_ctrl_assertions #(
	parameter int DEPTH = 2048,
	parameter int WIDTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	input wire logic             REF_CLK,
	input wire logic             RST,
	input wire logic             REQ_VALID,
	input wire logic             REQ_READY,
	input wire logic             RSP_VALID,
	input wire logic             B_LOAD,
	input wire logic             B_EN_IN,
	input wire logic             C_LOAD,
	input wire logic             C_EN_IN,
	input wire logic             PORT_A_STROBE_N,
	input wire logic             WRITE_STROBE_ALT_N,
	input wire logic             PORT_B_STROBE_N,
	input wire logic             PORT_C_STROBE_N,
	input wire logic [1:0]       REQ_OP,
	input wire logic [WIDTH-1:0] RSP_RDATA,
	input wire logic [WIDTH-1:0] PORT_A_DOUT,
	input wire logic [AW-1:0]    B_ADDR_IN,
	input wire logic [AW-1:0]    C_ADDR_IN,
	input wire logic [AW-1:0]    WRITE_PORT_ADDR,
	input wire logic [AW-1:0]    READ_PORT_B_ADDR,
	input wire logic [AW-1:0]    READ_PORT_C_ADDR
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	logic take;
	assign take = REQ_VALID && REQ_READY;
	a_busy_span: assert property (
		take |=> !REQ_READY [*6] ##1 REQ_READY) else $error("busy span wrong");
	a_read_walk: assert property (
		take && REQ_OP == 2'h0 |=> PORT_A_STROBE_N ##1 (!PORT_A_STROBE_N && WRITE_STROBE_ALT_N) [*3]
		##1 (PORT_A_STROBE_N && RSP_VALID)) else $error("read walk wrong");
	a_strobe_write: assert property (
		take && REQ_OP == 2'h1 |=> PORT_A_STROBE_N ##1 (!PORT_A_STROBE_N && !WRITE_STROBE_ALT_N) [*3]
		##1 (!PORT_A_STROBE_N && WRITE_STROBE_ALT_N) ##1 PORT_A_STROBE_N) else $error("we write");
	a_enable_write: assert property (
		take && REQ_OP[1] |=> WRITE_STROBE_ALT_N ##1 (!PORT_A_STROBE_N && !WRITE_STROBE_ALT_N) [*3]
		##1 (PORT_A_STROBE_N && !WRITE_STROBE_ALT_N) ##1 WRITE_STROBE_ALT_N) else $error("en write");
	a_rdata_taken: assert property (
		RSP_VALID |-> RSP_RDATA == $past(PORT_A_DOUT) ##1 !RSP_VALID) else $error("rdata wrong");
	a_addr_quiet: assert property (
		$changed(WRITE_PORT_ADDR) |-> WRITE_STROBE_ALT_N && PORT_A_STROBE_N) else $error("addr move");
	a_port_b_load: assert property (
		B_LOAD |=> READ_PORT_B_ADDR == $past(B_ADDR_IN) && PORT_B_STROBE_N == !$past(B_EN_IN))
		else $error("port b pins wrong");
	a_port_c_load: assert property (
		C_LOAD |=> READ_PORT_C_ADDR == $past(C_ADDR_IN) && PORT_C_STROBE_N == !$past(C_EN_IN))
		else $error("port c pins wrong");
	cover property (take && REQ_OP == 2'h0);
	cover property (take && REQ_OP == 2'h1);
	cover property (take && REQ_OP == 2'h2);
endmodule : tpr_ctrl_assertions
bind tpr_ctrl tpr_ctrl_assertions #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) chk_u (.*);
`default_nettype wire

// ---- verif/tpr_ram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// behavioural memory; no reset, contents survive a controller reset
module tpr_ram_model #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 8,
	parameter int AW    = 4
) (
	input wire logic [AW-1:0]    WRITE_PORT_ADDR,
	input wire logic [AW-1:0]    READ_PORT_B_ADDR,
	input wire logic [AW-1:0]    READ_PORT_C_ADDR,
	input wire logic [WIDTH-1:0] WRITE_DATA,
	input wire logic             PORT_A_STROBE_N,
	input wire logic             WRITE_STROBE_ALT_N,
	input wire logic             PORT_B_STROBE_N,
	input wire logic             PORT_C_STROBE_N,
	output logic [WIDTH-1:0]     PORT_A_DOUT,
	output logic [WIDTH-1:0]     B_DOUT,
	output logic [WIDTH-1:0]     C_DOUT
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] junk;
	// toggling filler so a stale word never passes for a good one
	initial begin
		junk = '0;
		forever #3 junk = ~junk;
	end
	always @* if (!PORT_A_STROBE_N && !WRITE_STROBE_ALT_N) mem[WRITE_PORT_ADDR] = WRITE_DATA;
	assign PORT_A_DOUT = (!PORT_A_STROBE_N && WRITE_STROBE_ALT_N) ? mem[WRITE_PORT_ADDR] : junk;
	assign B_DOUT = PORT_B_STROBE_N ? junk : mem[READ_PORT_B_ADDR];
	assign C_DOUT = PORT_C_STROBE_N ? junk : mem[READ_PORT_C_ADDR];
endmodule : tpr_ram_model
`default_nettype wire

// ---- verif/tpr_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpr_ctrl_tb
	import tpr_pkg::*;
;
	localparam int DEPTH = 16;
	localparam int WIDTH = 8;
	localparam int AW    = 4;
	logic             REF_CLK, RST, REQ_VALID, REQ_READY, RSP_VALID, B_LOAD, B_EN_IN, C_LOAD, C_EN_IN;
	logic             PORT_A_STROBE_N, WRITE_STROBE_ALT_N, PORT_B_STROBE_N, PORT_C_STROBE_N;
	logic [1:0]       REQ_OP;
	logic [AW-1:0]    REQ_ADDR, B_ADDR_IN, C_ADDR_IN, WRITE_PORT_ADDR, READ_PORT_B_ADDR, READ_PORT_C_ADDR;
	logic [WIDTH-1:0] REQ_WDATA, RSP_RDATA, WRITE_DATA, PORT_A_DOUT, B_DOUT, C_DOUT;
	logic [WIDTH-1:0] shadow [DEPTH];
	logic [WIDTH-1:0] exp_q [$];
	int               mismatches, cmp_count, seed;
	tpr_ctrl #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) dut_u (.*);
	tpr_ram_model #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) ram_u (.*);
	task automatic chk(input logic [WIDTH-1:0] seen, input logic [WIDTH-1:0] want);
		cmp_count++;
		if (seen !== want) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic req(input logic [1:0] op, input logic [AW-1:0] a, input logic [WIDTH-1:0] d);
		int n;
		n = 0;
		while (REQ_READY !== 1'h1 && n < 20) begin
			@(negedge REF_CLK);
			n++;
		end
		if (n == 20) mismatches++;
		{REQ_VALID, REQ_OP, REQ_ADDR, REQ_WDATA} = {1'h1, op, a, d};
		@(negedge REF_CLK);
		REQ_VALID = 1'h0;
		if (op == TPR_OP_READ) exp_q.push_back(shadow[a]);
		else shadow[a] = d;
	endtask : req
	initial begin
		REF_CLK = 1'h0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	always @(negedge REF_CLK) if (RSP_VALID === 1'h1) begin
		chk(RSP_RDATA, exp_q.size() ? exp_q.pop_front() : 'x);
	end
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		seed = 32'hD6D1;
		{REQ_VALID, REQ_OP, REQ_ADDR, REQ_WDATA, B_LOAD, B_EN_IN, B_ADDR_IN} = '0;
		{C_LOAD, C_EN_IN, C_ADDR_IN} = '0;
		RST = 1'h1;
		repeat (8) @(negedge REF_CLK);
		RST = 1'h0;
		for (int i = 0; i < DEPTH; i++) req(2'(1 + i % 3), AW'(i), WIDTH'($random(seed)));
		for (int i = 0; i < DEPTH; i++) req(TPR_OP_READ, AW'(DEPTH - 1 - i), 8'h00);
		$display("test write then read done");
		req(TPR_OP_WR_WE, 4'h5, 8'hA5);
		// a second request while busy must be dropped
		@(negedge REF_CLK);
		{REQ_VALID, REQ_WDATA} = {1'h1, 8'h3C};
		@(negedge REF_CLK);
		REQ_VALID = 1'h0;
		req(TPR_OP_READ, 4'h5, 8'h00);
		$display("test busy refusal done");
		for (int i = 0; i < DEPTH; i++) begin
			{B_LOAD, B_EN_IN, B_ADDR_IN, C_LOAD, C_EN_IN, C_ADDR_IN} = {2'h3, AW'(i), 2'h3, AW'(~i)};
			if (i == 4) req(TPR_OP_WR_EN, 4'hA, WIDTH'($random(seed)));
			@(negedge REF_CLK);
			{B_LOAD, C_LOAD} = 2'h0;
			repeat (8) @(negedge REF_CLK);
			chk(B_DOUT, shadow[i]);
			chk(C_DOUT, shadow[AW'(~i)]);
		end
		{B_LOAD, B_EN_IN} = 2'h2;
		@(negedge REF_CLK);
		B_LOAD = 1'h0;
		@(negedge REF_CLK);
		chk(WIDTH'(PORT_B_STROBE_N), 8'h01);
		$display("test read ports done");
		// reset lands in the middle of a strobe-timed write
		req(TPR_OP_WR_WE, 4'h3, 8'h5A);
		@(negedge REF_CLK);
		RST = 1'h1;
		@(negedge REF_CLK);
		chk(WIDTH'({REQ_READY, RSP_VALID, PORT_A_STROBE_N, WRITE_STROBE_ALT_N}), 8'h0B);
		RST = 1'h0;
		req(TPR_OP_READ, 4'hA, 8'h00);
		repeat (10) @(negedge REF_CLK);
		chk(WIDTH'(exp_q.size()), 8'h00);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : tpr_ctrl_tb
`default_nettype wire
